// ===== hdl/dev_cfg_debug.sv
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// RULE_01 - Word2 bits 18:16 select PLL output divider
// RULE_02 - Word2 bit 15 high bypasses USB PLL
// RULE_03 - Word2 bits 10:8 select USB input divider
// RULE_04 - Word2 bits 6:4 select PLL multiplier
// RULE_05 - Word2 bits 2:0 select PLL input divider
// RULE_06 - Word3 bit 31 gives bus-power pin USB
// RULE_07 - Word3 bit 30 gives ident pin USB
// RULE_08 - Word3 bit 26 picks CAN pins, absent reads 1
// RULE_09 - Word3 bit 25 picks Ethernet pins, absent reads 1
// RULE_10 - Word3 bit 24 selects MII or RMII
// RULE_11 - Word3 bits 18:16 pick shadow priority
// RULE_12 - Word3 bits 15:0 hold user identifier
// RULE_13 - Identity word read-only, revision and part
// RULE_14 - Debug bit 3 enables JTAG, resets 1
// RULE_15 - Debug bit 2 enables trace, resets 0
// RULE_16 - Debug bit 0 two-wire TDO use, resets 0
// RULE_17 - Other debug bits read zero, ignore writes
// RULE_18 - Hold execution for start-up after power-down
// RULE_19 - Brown-out makes reset, flagged in bit 1
// RULE_20 - Config words sampled at reset, then held
module dev_cfg_debug
  import cfg_pkg::*;
#(
  parameter logic        HAS_CAN = 1'b1,
  parameter logic        HAS_ETH = 1'b1,
  parameter logic [3:0]  REVISION = REVISION_DEFAULT,
  parameter logic [27:0] PART     = PART_DEFAULT
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Non-volatile configuration words
  input  wire logic [31:0] nv_word2,
  input  wire logic [31:0] nv_word3,
  // Power events
  input  wire logic        wake_req,
  input  wire logic        sleep_req,
  input  wire logic        supply_low,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Clock system controls
  output logic      [8:0]  sys_out_div,
  output logic             usb_pll_bypass,
  output logic      [3:0]  usb_pll_in_div,
  output logic      [4:0]  sys_pll_mult,
  output logic      [3:0]  sys_pll_in_div,
  // Pin ownership and modes
  output logic             vbus_pin_owner,
  output logic             usb_id_pin_owner,
  output logic             can_pin_alt_sel,
  output logic             eth_pin_alt_sel,
  output logic             phy_if_mode_sel,
  output logic      [2:0]  shadow_set_prio_sel,
  output logic      [15:0] user_ident,
  // Debug port controls
  output logic             jtag_port_en,
  output logic             trace_out_en,
  output logic             two_wire_tdo_use,
  // Execution gating and brown-out
  output logic             cpu_run,
  output logic             brownout_reset
);

  cfg_store_if st ();

  seq_state_t  state;
  seq_state_t  next_state;
  logic [15:0] hold_cnt;
  logic [31:0] debug_port_control;
  logic        brown_flag;
  logic        loaded;

  // Shadow store for the sampled words
  cfg_shadow u_shadow (
    .sys_clk (sys_clk),
    .rst     (rst),
    .st      (st)
  );

  // Words sampled once after reset release
  assign st.load  = (state == ST_LOAD) && !loaded; // RULE_20
  assign st.word2 = nv_word2;
  assign st.word3 = nv_word3;

  wire [31:0] pll_usb_config_word = st.shadow2;

  // Variants without a controller force the select to 1
  wire can_sel = HAS_CAN ? st.shadow3[CAN_SEL_BIT] : 1'b1; // RULE_08
  wire eth_sel = HAS_ETH ? st.shadow3[ETH_SEL_BIT] : 1'b1; // RULE_09
  wire phy_sel = HAS_ETH ? st.shadow3[PHY_MODE_BIT] : 1'b1; // RULE_10
  wire [31:0] pin_owner_config_word = {st.shadow3[31:27], can_sel, eth_sel, phy_sel, st.shadow3[23:0]};

  wire [31:0] silicon_identity = {REVISION, PART}; // RULE_13

  wire [2:0] out_code  = pll_usb_config_word[SYS_OUT_DIV_LSB +: 3];
  wire [2:0] uin_code  = pll_usb_config_word[USB_IN_DIV_LSB +: 3];
  wire [2:0] mul_code  = pll_usb_config_word[SYS_MULT_LSB +: 3];
  wire [2:0] sin_code  = pll_usb_config_word[SYS_IN_DIV_LSB +: 3];

  // Output divider: powers of two, top code 256
  wire [8:0] next_out_div = (out_code == 3'h7) ? 9'h100 : (9'h001 << out_code); // RULE_01

  // Input divider table shared by both PLLs
  function automatic logic [3:0] in_div(input logic [2:0] c);
    case (c)
      3'h6:    in_div = 4'ha;
      3'h7:    in_div = 4'hc;
      default: in_div = {1'b0, c} + 4'h1;
    endcase
  endfunction : in_div

  wire [3:0] next_usb_div = in_div(uin_code); // RULE_03
  wire [3:0] next_sys_div = in_div(sin_code); // RULE_05
  // Multiplier 15..21, top code 24
  wire [4:0] next_mult = (mul_code == 3'h7) ? 5'h18 : (5'h0f + {2'h0, mul_code}); // RULE_04

  // Register decode
  wire sel_pll   = (reg_addr == OFF_PLL_USB_CFG);
  wire sel_pin   = (reg_addr == OFF_PIN_OWN_CFG);
  wire sel_id    = (reg_addr == OFF_IDENTITY);
  wire sel_dbg   = (reg_addr == OFF_DEBUG_CTRL);
  wire sel_cause = (reg_addr == OFF_RESET_CAUSE);
  wire sel_stat  = (reg_addr == OFF_STATUS);

  logic [31:0] next_rdata;
  // Read mux; unmapped addresses read zero
  always_comb begin
    if (sel_pll)        next_rdata = pll_usb_config_word;
    else if (sel_pin)   next_rdata = pin_owner_config_word;
    else if (sel_id)    next_rdata = silicon_identity;
    else if (sel_dbg)   next_rdata = debug_port_control;
    else if (sel_cause) next_rdata = {30'h0, brown_flag, 1'b0};
    else if (sel_stat)  next_rdata = {30'h0, state};
    else                next_rdata = 32'h0;
  end

  // Read data register
  always_ff @(posedge sys_clk) begin
    if (rst)         reg_rdata <= 32'h0;
    else if (reg_rd) reg_rdata <= next_rdata;
    else             reg_rdata <= 32'h0;
  end

  // Debug control; unimplemented bits masked to zero
  always_ff @(posedge sys_clk) begin
    if (rst)                  debug_port_control <= DEBUG_CTRL_RESET; // RULE_14 RULE_15 RULE_16
    else if (reg_wr && sel_dbg) debug_port_control <= reg_wdata & DEBUG_CTRL_MASK; // RULE_17
  end

  // Brown-out flag: set wins over a software clear of bit 1
  wire brown_clr = reg_wr && sel_cause && !reg_wdata[BROWNOUT_BIT];
  always_ff @(posedge sys_clk) begin
    if (rst)             brown_flag <= 1'b0;
    else if (supply_low) brown_flag <= 1'b1; // RULE_19
    else if (brown_clr)  brown_flag <= 1'b0;
  end

  // Hold-off sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_LOAD:  next_state = ST_WAIT;
      ST_WAIT:  if (hold_cnt == 16'(STARTUP_CYCLES - 1)) next_state = ST_RUN; // RULE_18
      ST_RUN:   if (sleep_req) next_state = ST_SLEEP;
      ST_SLEEP: if (wake_req) next_state = ST_WAIT; // RULE_18
      default:  next_state = ST_LOAD;
    endcase
    if (supply_low) next_state = ST_WAIT;
  end

  // State, counter and load marker
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state    <= ST_LOAD;
      hold_cnt <= 16'h0;
      loaded   <= 1'b0;
    end else begin
      state    <= next_state;
      hold_cnt <= (next_state == ST_WAIT && state == ST_WAIT) ? hold_cnt + 16'h1 : 16'h0;
      loaded   <= 1'b1;
    end
  end

  // Registered decoded outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sys_out_div         <= 9'h100;
      usb_pll_bypass      <= 1'b1;
      usb_pll_in_div      <= 4'hc;
      sys_pll_mult        <= 5'h18;
      sys_pll_in_div      <= 4'hc;
      vbus_pin_owner      <= 1'b1;
      usb_id_pin_owner    <= 1'b1;
      can_pin_alt_sel     <= 1'b1;
      eth_pin_alt_sel     <= 1'b1;
      phy_if_mode_sel     <= 1'b1;
      shadow_set_prio_sel <= 3'h7;
      user_ident          <= 16'hffff;
      jtag_port_en        <= 1'b1;
      trace_out_en        <= 1'b0;
      two_wire_tdo_use    <= 1'b0;
      cpu_run             <= 1'b0;
      brownout_reset      <= 1'b0;
    end else begin
      sys_out_div         <= next_out_div; // RULE_01
      usb_pll_bypass      <= pll_usb_config_word[USB_BYPASS_BIT]; // RULE_02
      usb_pll_in_div      <= next_usb_div; // RULE_03
      sys_pll_mult        <= next_mult; // RULE_04
      sys_pll_in_div      <= next_sys_div; // RULE_05
      vbus_pin_owner      <= pin_owner_config_word[VBUS_OWN_BIT]; // RULE_06
      usb_id_pin_owner    <= pin_owner_config_word[USB_IDENT_PIN_OWN_BIT]; // RULE_07
      can_pin_alt_sel     <= can_sel; // RULE_08
      eth_pin_alt_sel     <= eth_sel; // RULE_09
      phy_if_mode_sel     <= phy_sel; // RULE_10
      shadow_set_prio_sel <= pin_owner_config_word[SHADOW_LSB +: 3]; // RULE_11
      user_ident          <= pin_owner_config_word[USER_ID_LSB +: 16]; // RULE_12
      jtag_port_en        <= debug_port_control[JTAG_EN_BIT]; // RULE_14
      trace_out_en        <= debug_port_control[TRACE_EN_BIT]; // RULE_15
      two_wire_tdo_use    <= debug_port_control[TDO_USE_BIT]; // RULE_16
      cpu_run             <= (next_state == ST_RUN); // RULE_18
      brownout_reset      <= supply_low; // RULE_19
    end
  end

endmodule : dev_cfg_debug

// ===== hdl/cfg_pkg.sv
package cfg_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_PLL_USB_CFG  = 8'h00;
  localparam logic [7:0] OFF_PIN_OWN_CFG  = 8'h04;
  localparam logic [7:0] OFF_IDENTITY     = 8'h08;
  localparam logic [7:0] OFF_DEBUG_CTRL   = 8'h0c;
  localparam logic [7:0] OFF_RESET_CAUSE  = 8'h10;
  localparam logic [7:0] OFF_STATUS       = 8'h14;

  // Word 2 field positions
  localparam int SYS_OUT_DIV_LSB = 16;
  localparam int USB_BYPASS_BIT  = 15;
  localparam int USB_IN_DIV_LSB  = 8;
  localparam int SYS_MULT_LSB    = 4;
  localparam int SYS_IN_DIV_LSB  = 0;

  // Word 3 field positions
  localparam int VBUS_OWN_BIT    = 31;
  localparam int USB_IDENT_PIN_OWN_BIT   = 30;
  localparam int CAN_SEL_BIT     = 26;
  localparam int ETH_SEL_BIT     = 25;
  localparam int PHY_MODE_BIT    = 24;
  localparam int SHADOW_LSB      = 16;
  localparam int USER_ID_LSB     = 0;

  // Identity word layout
  localparam int REV_LSB         = 28;

  // Debug control bits and reset value
  localparam int JTAG_EN_BIT     = 3;
  localparam int TRACE_EN_BIT    = 2;
  localparam int TDO_USE_BIT     = 0;
  localparam logic [31:0] DEBUG_CTRL_RESET = 32'h0000_0008;
  localparam logic [31:0] DEBUG_CTRL_MASK  = 32'h0000_000d;

  // Reset-cause brown-out flag position
  localparam int BROWNOUT_BIT    = 1;

  // Arbitrary neutral identity values
  localparam logic [3:0]  REVISION_DEFAULT = 4'h1;
  localparam logic [27:0] PART_DEFAULT     = 28'h0000_abc;

  // Regulator start-up hold-off
  localparam int STARTUP_US      = 10;
  localparam int CLK_MHZ         = 20;
  localparam int STARTUP_CYCLES  = STARTUP_US * CLK_MHZ;

  // Hold-off sequencer states
  typedef enum logic [1:0] {
    ST_LOAD  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_RUN   = 2'b11,
    ST_SLEEP = 2'b10
  } seq_state_t;

endpackage : cfg_pkg

// ===== hdl/cfg_store_if.sv
`timescale 1ns/1ps
interface cfg_store_if;
  logic        load;
  logic [31:0] word2;
  logic [31:0] word3;
  logic [31:0] shadow2;
  logic [31:0] shadow3;
  modport owner (output load, output word2, output word3, input shadow2, input shadow3);
  modport store (input load, input word2, input word3, output shadow2, output shadow3);
endinterface : cfg_store_if

// ===== hdl/cfg_shadow.sv
`timescale 1ns/1ps
module cfg_shadow (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Capture port
  cfg_store_if.store st
);

  // Latch both words on load; hold them otherwise
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st.shadow2 <= 32'hffff_ffff;
      st.shadow3 <= 32'hffff_ffff;
    end else if (st.load) begin
      st.shadow2 <= st.word2;
      st.shadow3 <= st.word3;
    end
  end

endmodule : cfg_shadow

// ===== bench/dev_cfg_debug_props.sv
`timescale 1ns/1ps
module dev_cfg_debug_props
  import cfg_pkg::*;
#(
  parameter logic [3:0]  REVISION = REVISION_DEFAULT,
  parameter logic [27:0] PART     = PART_DEFAULT
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Stimulus
  input wire logic        supply_low,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  // Responses
  input wire logic [31:0] reg_rdata,
  input wire logic [8:0]  sys_out_div,
  input wire logic [15:0] user_ident,
  input wire logic        jtag_port_en,
  input wire logic        cpu_run,
  input wire logic        brownout_reset
);
  logic [8:0] low_cnt;
  logic [1:0] up_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Halted cycles, and cycles since reset release (both saturate)
  always_ff @(posedge sys_clk) begin
    low_cnt <= (rst || cpu_run) ? 9'h000 : ((low_cnt == 9'h1ff) ? low_cnt : low_cnt + 9'h001);
    up_cnt  <= rst ? 2'h0 : ((up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1);
  end
  // Debug write, then its effect two cycles later
  sequence s_dbg_wr;
    reg_wr && reg_addr == OFF_DEBUG_CTRL ##1 1'b1;
  endsequence
  property p_jtag;
    s_dbg_wr |=> jtag_port_en == $past(reg_wdata[JTAG_EN_BIT], 2);
  endproperty
  property p_ident;
    reg_rd && reg_addr == OFF_IDENTITY |=> reg_rdata == {REVISION, PART};
  endproperty
  property p_dbg_zero;
    reg_rd && reg_addr == OFF_DEBUG_CTRL |=> (reg_rdata & ~DEBUG_CTRL_MASK) == 32'h0000_0000;
  endproperty
  property p_user;
    reg_rd && reg_addr == OFF_PIN_OWN_CFG && up_cnt == 2'h3 |=> reg_rdata[15:0] == user_ident;
  endproperty
  property p_odiv;
    reg_rd && reg_addr == OFF_PLL_USB_CFG && up_cnt == 2'h3 |=>
      sys_out_div == ((reg_rdata[18:16] == 3'h7) ? 9'h100 : (9'h001 << reg_rdata[18:16]));
  endproperty
  property p_hold;
    up_cnt == 2'h3 |-> $stable(user_ident) && $stable(sys_out_div);
  endproperty
  property p_bor;
    supply_low |=> brownout_reset ##1 !cpu_run;
  endproperty
  property p_startup;
    $rose(cpu_run) |-> low_cnt >= STARTUP_CYCLES - 1;
  endproperty
  a_jtag: assert property (p_jtag) else $error("jtag enable not following write");
  a_ident: assert property (p_ident) else $error("identity word wrong");
  a_dbg_zero: assert property (p_dbg_zero) else $error("unused debug bits not zero");
  a_user: assert property (p_user) else $error("user id output differs from word");
  a_odiv: assert property (p_odiv) else $error("output divider decode wrong");
  a_hold: assert property (p_hold) else $error("config outputs moved");
  a_bor: assert property (p_bor) else $error("brown-out not flagged");
  a_startup: assert property (p_startup) else $error("start-up hold-off too short");
endmodule : dev_cfg_debug_props
bind dev_cfg_debug dev_cfg_debug_props #(.REVISION(REVISION), .PART(PART)) u_dev_cfg_debug_props (.sys_clk,
  .rst, .supply_low, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sys_out_div, .user_ident,
  .jtag_port_en, .cpu_run, .brownout_reset);

// ===== bench/nv_store_model.sv
`timescale 1ns/1ps
module nv_store_model (
  // Pattern select
  input  wire logic [2:0]  code,
  // Stored words
  output logic      [31:0] nv_word2,
  output logic      [31:0] nv_word3
);
  // One code in every field, reserved bits at 1, held between resets
  assign nv_word2 = {13'h1fff, code, code[0], 4'hf, code, 1'b1, code, 1'b1, code};
  assign nv_word3 = {code[0], code[1], 3'h7, code[2], code[1], code[0], 5'h1f, code, code, 13'h1234};
endmodule : nv_store_model

// ===== bench/tb_dev_cfg_debug.sv
`timescale 1ns/1ps
module tb_dev_cfg_debug;
  import cfg_pkg::*;
  logic        sys_clk, rst, wake_req, sleep_req, supply_low, reg_wr, reg_rd, usb_pll_bypass;
  logic        vbus_pin_owner, usb_id_pin_owner, can_pin_alt_sel, eth_pin_alt_sel, phy_if_mode_sel;
  logic        jtag_port_en, trace_out_en, two_wire_tdo_use, cpu_run, brownout_reset;
  logic [2:0]  code, shadow_set_prio_sel;
  logic [3:0]  usb_pll_in_div, sys_pll_in_div;
  logic [4:0]  sys_pll_mult;
  logic [7:0]  reg_addr;
  logic [8:0]  sys_out_div;
  logic [15:0] user_ident;
  logic [31:0] reg_wdata, reg_rdata, nv_word2, nv_word3, rd_val;
  int          failures, n_checks;
  int          odiv[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
  int          idiv[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
  int          mult[8] = '{15, 16, 17, 18, 19, 20, 21, 24};

  dev_cfg_debug u_dev_cfg_debug (.sys_clk, .rst, .nv_word2, .nv_word3, .wake_req, .sleep_req, .supply_low,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sys_out_div, .usb_pll_bypass, .usb_pll_in_div,
    .sys_pll_mult, .sys_pll_in_div, .vbus_pin_owner, .usb_id_pin_owner, .can_pin_alt_sel, .eth_pin_alt_sel,
    .phy_if_mode_sel, .shadow_set_prio_sel, .user_ident, .jtag_port_en, .trace_out_en, .two_wire_tdo_use,
    .cpu_run, .brownout_reset);
  nv_store_model u_nv_store_model (.code, .nv_word2, .nv_word3);

  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  task automatic do_reset(input logic [2:0] c);
    @(posedge sys_clk);
    rst  <= 1'b1;
    code <= c;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : do_reset

  // Cycles until execution resumes, with a ceiling
  task automatic time_run(input int lo);
    int n = 0;
    while (cpu_run !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check(32'(n >= lo && n <= STARTUP_CYCLES + 4), 32'h1);
  endtask : time_run

  task automatic pulse(input int which);
    @(posedge sys_clk);
    {supply_low, sleep_req, wake_req} <= 3'(which);
    @(posedge sys_clk);
    {supply_low, sleep_req, wake_req} <= 3'h0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : pulse

  // Main sequence
  initial begin
    {rst, code, wake_req, sleep_req, supply_low, reg_wr, reg_rd} = 9'h100;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    for (int i = 0; i < 8; i++) begin
      do_reset(3'(i));
      check(32'(sys_out_div), 32'(odiv[i]));
      check(32'(usb_pll_bypass), 32'(code[0]));
      check(32'(usb_pll_in_div), 32'(idiv[i]));
      check(32'(sys_pll_mult), 32'(mult[i]));
      check(32'(sys_pll_in_div), 32'(idiv[i]));
      check(32'({vbus_pin_owner, usb_id_pin_owner}), 32'({code[0], code[1]}));
      check(32'(can_pin_alt_sel), 32'(code[2]));
      check(32'({eth_pin_alt_sel, phy_if_mode_sel}), 32'({code[1], code[0]}));
      check(32'(shadow_set_prio_sel), 32'(code));
      check(32'(user_ident), 32'({code, 13'h1234}));
      rd(OFF_PLL_USB_CFG);
      check(rd_val, nv_word2);
    end
    $display("decode test done");
    time_run(STARTUP_CYCLES - 4);
    rd(OFF_IDENTITY);
    check(rd_val, {REVISION_DEFAULT, PART_DEFAULT});
    wr(OFF_IDENTITY, 32'h0);
    rd(OFF_IDENTITY);
    check(rd_val, {REVISION_DEFAULT, PART_DEFAULT});
    wr(8'h40, 32'h0);
    rd(OFF_DEBUG_CTRL);
    check(rd_val, 32'h0000_0008);
    wr(OFF_DEBUG_CTRL, 32'hffff_ffff);
    rd(OFF_DEBUG_CTRL);
    check(rd_val, 32'h0000_000d);
    check(32'({jtag_port_en, trace_out_en, two_wire_tdo_use}), 32'h7);
    wr(OFF_DEBUG_CTRL, 32'h0);
    rd(OFF_DEBUG_CTRL);
    check(32'({jtag_port_en, trace_out_en, two_wire_tdo_use, rd_val}), 32'h0);
    $display("register test done");
    pulse(4);
    check(32'(cpu_run), 32'h0);
    rd(OFF_RESET_CAUSE);
    check(rd_val & 32'h2, 32'h2);
    time_run(STARTUP_CYCLES - 8);
    wr(OFF_RESET_CAUSE, 32'h0);
    rd(OFF_RESET_CAUSE);
    check(rd_val & 32'h2, 32'h0);
    pulse(2);
    check(32'(cpu_run), 32'h0);
    pulse(1);
    time_run(STARTUP_CYCLES - 8);
    rd(OFF_STATUS);
    check(rd_val, 32'(ST_RUN));
    $display("power test done");
    give_verdict();
  end

  // Watchdog
  initial begin
    #(6000 * 50);
    failures++;
    give_verdict();
  end
endmodule : tb_dev_cfg_debug
